// >>> logic/tcdb_pkg.sv
// shared types and constants for the timer, counter and deadband block
package tcdb_pkg;

	// data path geometry
	localparam int BYTE_W      = 8;
	localparam int CHAIN_BYTES = 2;
	localparam int CNT_W       = BYTE_W * CHAIN_BYTES;
	localparam int IDX_W       = 1;

	// reset and constant values
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
	localparam logic [IDX_W-1:0]  LSB_IDX   = 1'h0;

	// function selected for the block
	typedef enum logic [1:0] {
		FN_TIMER,
		FN_COUNTER,
		FN_DEADBAND
	} func_t;

	// data register addressed by a cpu access
	typedef enum logic [1:0] {
		REG_COUNT,
		REG_PERIOD,
		REG_COMPARE
	} reg_sel_t;

	// one cpu access, wr and rd are one-cycle strobes
	typedef struct packed {
		logic              wr;
		logic              rd;
		reg_sel_t          sel;
		logic [IDX_W-1:0]  byte_idx;
		logic [BYTE_W-1:0] wdata;
	} cpu_req_t;

	// function register mode bits
	typedef struct packed {
		func_t func;
		logic  int_on_compare;
		logic  cmp_le;
	} mode_cfg_t;

endpackage

// >>> logic/sync3_filter.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sync3_filter (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic srst,
	// asynchronous input and clean level
	input  wire logic async_in,
	output logic      level_out
);

	logic stage1;
	logic stage2;
	logic stage3;

	// stage1 feeds only stage2
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a single-cycle glitch never reaches the level
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			level_out <= 1'b0;
		end else if (stage2 == stage3) begin
			level_out <= stage3;
		end
	end

endmodule // sync3_filter

`default_nettype wire

// >>> logic/timer_counter_deadband_block.sv
// programmable digital block: timer with capture, counter with compare, deadband generator
`timescale 1ns/1ps
`default_nettype none

module timer_counter_deadband_block (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        srst,
	// cpu access
	input  wire tcdb_pkg::cpu_req_t          cpu_req,
	output logic [tcdb_pkg::BYTE_W-1:0]      cpu_rdata,
	// configuration
	input  wire logic                        block_enable,
	input  wire tcdb_pkg::mode_cfg_t         mode_cfg,
	input  wire logic                        data_in_external,
	// inputs from neighbouring blocks
	input  wire logic                        source_clk,
	input  wire logic                        data_in,
	input  wire logic                        deadband_in,
	// function outputs
	output logic                             primary_out,
	output logic                             aux_out,
	output logic                             primary_phase_out,
	output logic                             complementary_phase_out,
	output logic                             block_irq,
	// status
	output logic [tcdb_pkg::CNT_W-1:0]       count_status
);

	// deadband sequencer states
	typedef enum logic [2:0] {
		DB_IDLE,
		DB_DEAD_RISE,
		DB_PRIMARY,
		DB_DEAD_FALL,
		DB_COMPLEMENT
	} db_state_t;

	// pick one byte out of a chained value
	function automatic logic [tcdb_pkg::BYTE_W-1:0] get_byte(
		input logic [tcdb_pkg::CNT_W-1:0] vec,
		input logic [tcdb_pkg::IDX_W-1:0] idx
	);
		get_byte = vec[idx*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W];
	endfunction

	// replace one byte of a chained value
	function automatic logic [tcdb_pkg::CNT_W-1:0] put_byte(
		input logic [tcdb_pkg::CNT_W-1:0]  vec,
		input logic [tcdb_pkg::IDX_W-1:0]  idx,
		input logic [tcdb_pkg::BYTE_W-1:0] val
	);
		logic [tcdb_pkg::CNT_W-1:0] tmp;
		tmp = vec;
		tmp[idx*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W] = val;
		put_byte = tmp;
	endfunction

	// registers
	logic [tcdb_pkg::CNT_W-1:0] period;
	logic [tcdb_pkg::CNT_W-1:0] compare;
	db_state_t                  db_state;

	// input conditioning
	logic src_lvl;
	logic src_prev;
	logic data_sync;
	logic data_lvl;
	logic data_prev;
	logic db_prev;
	logic en_last;

	// output stage
	logic tc_q;
	logic cmp_q;
	logic phase0;
	logic phase1;
	logic irq_src_prev;

	// combinational helpers
	logic                       src_rise;
	logic                       src_fall;
	logic                       tick;
	logic                       data_rise;
	logic                       db_rise;
	logic                       db_fall;
	logic                       count_zero;
	logic                       run;
	logic                       cmp_true;
	logic                       is_timer;
	logic                       is_counter;
	logic                       is_deadband;
	logic                       wr_period;
	logic                       wr_compare;
	logic                       rd_count;
	logic                       cap_all;
	logic                       irq_src;
	logic                       kill;
	logic [tcdb_pkg::CNT_W-1:0] next_period;
	logic [tcdb_pkg::CNT_W-1:0] reload;

	// source clock arrives from outside the system clock domain
	sync3_filter u_src_sync (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.async_in  (source_clk),
		.level_out (src_lvl)
	);

	// enable, capture or kill on data_in is synchronised before use only when data_in_external is set
	sync3_filter u_data_sync (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.async_in  (data_in),
		.level_out (data_sync)
	);

	assign data_lvl = data_in_external ? data_sync : data_in;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			src_prev  <= 1'b0;
			data_prev <= 1'b0;
			db_prev   <= 1'b0;
		end else begin
			src_prev  <= src_lvl;
			data_prev <= data_lvl;
			db_prev   <= deadband_in;
		end
	end

	// decode
	assign is_timer    = (mode_cfg.func == tcdb_pkg::FN_TIMER);
	assign is_counter  = (mode_cfg.func == tcdb_pkg::FN_COUNTER);
	assign is_deadband = (mode_cfg.func == tcdb_pkg::FN_DEADBAND);
	assign wr_period   = cpu_req.wr && (cpu_req.sel == tcdb_pkg::REG_PERIOD);
	assign wr_compare  = cpu_req.wr && (cpu_req.sel == tcdb_pkg::REG_COMPARE);
	assign rd_count    = cpu_req.rd && (cpu_req.sel == tcdb_pkg::REG_COUNT);
	assign next_period = put_byte(period, cpu_req.byte_idx, cpu_req.wdata);

	// block clock is gated off while disabled
	assign src_rise  = src_lvl && !src_prev;
	assign src_fall  = !src_lvl && src_prev;
	assign tick      = block_enable && src_rise;
	assign data_rise = data_lvl && !data_prev;
	assign db_rise   = deadband_in && !db_prev;
	assign db_fall   = !deadband_in && db_prev;
	assign kill      = is_deadband && data_lvl;

	// whole-chain zero test: tc only when every byte is zero
	assign count_zero = (count_status == tcdb_pkg::CNT_ZERO);

	// one extra count when enable drops in the terminal count period
	assign run = data_lvl || (count_zero && en_last);

	assign cmp_true = mode_cfg.cmp_le ? (count_status <= compare)
		: (count_status < compare);

	// deadband reloads only the low byte, upper bytes stay clear
	assign reload = is_deadband
		? {{(tcdb_pkg::CNT_W-tcdb_pkg::BYTE_W){1'b0}}, period[tcdb_pkg::BYTE_W-1:0]}
		: period;

	// period register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			period <= tcdb_pkg::CNT_ZERO;
		end else if (wr_period) begin
			period <= next_period;
		end
	end

	// enable seen at the last block clock edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			en_last <= 1'b0;
		end else if (tick) begin
			en_last <= data_lvl;
		end
	end

	// down counter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			count_status <= tcdb_pkg::CNT_ZERO;
		end else if (!block_enable) begin
			// count is kept while disabled, only a period write moves it
			if (wr_period) begin
				count_status <= next_period;
			end
		end else if (is_deadband) begin
			if (db_rise || db_fall) begin
				count_status <= reload;
			end else if (tick && !count_zero &&
				(db_state == DB_DEAD_RISE || db_state == DB_DEAD_FALL)) begin
				count_status <= count_status - tcdb_pkg::CNT_ONE;
			end
		end else if (tick && (is_timer || run)) begin
			// full-width decrement borrows into the upper byte whenever the low byte alone is zero
			if (count_zero) begin
				count_status <= reload;
			end else begin
				count_status <= count_status - tcdb_pkg::CNT_ONE;
			end
		end
	end

	// capture of all bytes on a hardware edge or a low-byte read while running
	assign cap_all = block_enable && !is_deadband && ((is_timer && data_rise) ||
		(rd_count && cpu_req.byte_idx == tcdb_pkg::LSB_IDX));

	// compare/capture register, one byte lane each
	for (genvar g = 0; g < tcdb_pkg::CHAIN_BYTES; g++) begin : g_cmp_lane
		logic rd_this;
		logic wr_this;
		assign rd_this = rd_count && !is_deadband &&
			(cpu_req.byte_idx == tcdb_pkg::IDX_W'(g));
		assign wr_this = wr_compare && (cpu_req.byte_idx == tcdb_pkg::IDX_W'(g));
		// capture beats a cpu write landing in the same cycle
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				compare[g*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W] <= tcdb_pkg::BYTE_ZERO;
			end else if (cap_all || rd_this) begin
				compare[g*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W] <=
					count_status[g*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W];
			end else if (wr_this) begin
				compare[g*tcdb_pkg::BYTE_W +: tcdb_pkg::BYTE_W] <= cpu_req.wdata;
			end
		end
	end

	// read data; a count read always answers zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cpu_rdata <= tcdb_pkg::BYTE_ZERO;
		end else if (cpu_req.rd) begin
			unique case (cpu_req.sel)
				tcdb_pkg::REG_COUNT: begin
					cpu_rdata <= tcdb_pkg::BYTE_ZERO;
				end
				tcdb_pkg::REG_PERIOD: begin
					cpu_rdata <= get_byte(period, cpu_req.byte_idx);
				end
				tcdb_pkg::REG_COMPARE: begin
					cpu_rdata <= get_byte(compare, cpu_req.byte_idx);
				end
				default: begin
					cpu_rdata <= tcdb_pkg::BYTE_ZERO;
				end
			endcase
		end
	end

	// terminal count follows the count register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tc_q <= 1'b0;
		end else begin
			tc_q <= block_enable && !is_deadband && count_zero;
		end
	end

	// compare output; the counter updates it only on source falling edges
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmp_q <= 1'b0;
		end else if (!block_enable || is_deadband) begin
			cmp_q <= 1'b0;
		end else if (is_timer || src_fall) begin
			cmp_q <= cmp_true;
		end
	end

	// deadband sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			db_state <= DB_IDLE;
			phase0   <= 1'b0;
			phase1   <= 1'b0;
		end else if (!block_enable || !is_deadband) begin
			db_state <= DB_IDLE;
			phase0   <= 1'b0;
			phase1   <= 1'b0;
		end else if (db_rise) begin
			db_state <= DB_DEAD_RISE;
			phase1   <= 1'b0;
		end else if (db_fall) begin
			db_state <= DB_DEAD_FALL;
			phase0   <= 1'b0;
		end else begin
			unique case (db_state)
				DB_DEAD_RISE: begin
					if (tick && count_zero) begin
						db_state <= DB_PRIMARY;
						phase0   <= 1'b1;
					end
				end
				DB_DEAD_FALL: begin
					if (tick && count_zero) begin
						db_state <= DB_COMPLEMENT;
						phase1   <= 1'b1;
					end
				end
				DB_IDLE, DB_PRIMARY, DB_COMPLEMENT: begin
					db_state <= db_state;
				end
				default: begin
					db_state <= DB_IDLE;
				end
			endcase
		end
	end

	// kill gates the phases but leaves the sequencer running
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			primary_phase_out       <= 1'b0;
			complementary_phase_out <= 1'b0;
		end else begin
			primary_phase_out       <= block_enable && phase0 && !kill;
			complementary_phase_out <= block_enable && phase1 && !kill;
		end
	end

	// routed outputs; deadband hands only its primary phase to the next block
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			primary_out <= 1'b0;
			aux_out     <= 1'b0;
		end else if (!block_enable) begin
			primary_out <= 1'b0;
			aux_out     <= 1'b0;
		end else begin
			unique case (mode_cfg.func)
				tcdb_pkg::FN_TIMER: begin
					primary_out <= tc_q;
					aux_out     <= cmp_q;
				end
				tcdb_pkg::FN_COUNTER: begin
					primary_out <= cmp_q;
					aux_out     <= tc_q;
				end
				tcdb_pkg::FN_DEADBAND: begin
					primary_out <= phase0 && !kill;
					aux_out     <= 1'b0;
				end
				default: begin
					primary_out <= 1'b0;
					aux_out     <= 1'b0;
				end
			endcase
		end
	end

	// interrupt source: selected level whose rising edge pulses the irq
	assign irq_src = is_deadband ? phase0
		: (mode_cfg.int_on_compare ? cmp_q : tc_q);

	// block_enable gates the irq pulse directly, not only through the count
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_src_prev <= 1'b0;
			block_irq    <= 1'b0;
		end else begin
			irq_src_prev <= irq_src;
			block_irq    <= block_enable && irq_src && !irq_src_prev;
		end
	end

endmodule // timer_counter_deadband_block

`default_nettype wire

// >>> testbench/tcdb_neighbour.sv
// neighbour model: source clock and previous-block pwm on the deadband input
`timescale 1ns/1ps
`default_nettype none

module tcdb_neighbour (
	// clock
	input  wire logic sys_clk,
	// run controls
	input  wire logic clk_run,
	input  wire logic pwm_run,
	// to the block
	output logic      source_clk,
	output logic      deadband_in
);
	localparam int HALF     = 8; // 12.5 MHz block clock keeps capture legal
	localparam int PWM_HALF = 160;
	int sc = 0;
	int pc = 0;
	// a stopped clock stands low rather than freezing mid-level
	always @(posedge sys_clk) begin
		sc <= (clk_run && sc < HALF - 1) ? sc + 1 : 0;
		source_clk <= clk_run && (sc == HALF - 1 ? !source_clk : source_clk);
		pc <= (pwm_run && pc < PWM_HALF - 1) ? pc + 1 : 0;
		deadband_in <= pwm_run && (pc == PWM_HALF - 1 ? !deadband_in : deadband_in);
	end
endmodule // tcdb_neighbour
`default_nettype wire

// >>> testbench/tcdb_block_properties.sv
// port checks for the timer, counter and deadband block
`timescale 1ns/1ps
`default_nettype none

module tcdb_block_checker (
	// clock and reset
	input wire logic                        sys_clk,
	input wire logic                        srst,
	// cpu and configuration
	input wire tcdb_pkg::cpu_req_t          cpu_req,
	input wire logic [tcdb_pkg::BYTE_W-1:0] cpu_rdata,
	input wire logic                        block_enable,
	input wire tcdb_pkg::mode_cfg_t         mode_cfg,
	input wire logic                        data_in_external,
	input wire logic                        data_in,
	// outputs
	input wire logic                        primary_out,
	input wire logic                        aux_out,
	input wire logic                        primary_phase_out,
	input wire logic                        complementary_phase_out,
	input wire logic                        block_irq,
	input wire logic [tcdb_pkg::CNT_W-1:0]  count_status
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	chk_no_overlap: assert property (!(primary_phase_out && complementary_phase_out))
		else $error("phases overlap");
	chk_disabled_low: assert property (!block_enable && !$past(block_enable) |->
		!(primary_out || aux_out || primary_phase_out || complementary_phase_out || block_irq))
		else $error("output high while disabled");
	chk_count_hold: assert property (!block_enable && !$past(block_enable)
		&& !$past(cpu_req.wr) |-> $stable(count_status)) else $error("count moved");
	chk_period_load: assert property (!block_enable && cpu_req.wr
		&& cpu_req.sel == tcdb_pkg::REG_PERIOD && cpu_req.byte_idx == tcdb_pkg::LSB_IDX
		|=> count_status[7:0] == $past(cpu_req.wdata)) else $error("period not loaded");
	chk_read_zero: assert property (cpu_req.rd && cpu_req.sel == tcdb_pkg::REG_COUNT
		|=> cpu_rdata == tcdb_pkg::BYTE_ZERO) else $error("count read not zero");
	chk_irq_pulse: assert property (block_irq |=> !block_irq)
		else $error("irq longer than one cycle");
	chk_kill_low: assert property (!data_in_external && data_in && $past(data_in)
		&& $past(data_in, 2) |-> !primary_phase_out && !complementary_phase_out)
		else $error("phase high under kill");
	chk_count_step: assert property (block_enable && $past(block_enable)
		&& !$past(cpu_req.wr) && mode_cfg.func != tcdb_pkg::FN_DEADBAND && $changed(count_status)
		|-> count_status == $past(count_status) - tcdb_pkg::CNT_ONE
		|| $past(count_status) == tcdb_pkg::CNT_ZERO) else $error("bad count step");
	chk_tc_follows: assert property (mode_cfg.func == tcdb_pkg::FN_COUNTER && block_enable
		&& $past(block_enable) && $past(block_enable, 2)
		|-> aux_out == ($past(count_status, 2) == tcdb_pkg::CNT_ZERO)) else $error("tc wrong");
endmodule // tcdb_block_checker

bind timer_counter_deadband_block tcdb_block_checker chk (.sys_clk, .srst, .cpu_req, .cpu_rdata,
	.block_enable, .mode_cfg, .data_in_external, .data_in, .primary_out, .aux_out,
	.primary_phase_out, .complementary_phase_out, .block_irq, .count_status);
`default_nettype wire

// >>> testbench/timer_counter_deadband_block_test.sv
// self-checking bench for the timer, counter and deadband block
`timescale 1ns/1ps
`default_nettype none

module timer_counter_deadband_block_test;
	logic                sys_clk = 1'b0;
	logic                srst = 1'b1;
	tcdb_pkg::cpu_req_t  cpu_req = '0;
	logic [7:0]          cpu_rdata;
	logic                block_enable = 1'b0;
	tcdb_pkg::mode_cfg_t mode_cfg = '0;
	logic                data_in_external = 1'b0;
	logic                data_in = 1'b0;
	logic                source_clk;
	logic                deadband_in;
	logic                primary_out;
	logic                aux_out;
	logic                primary_phase_out;
	logic                complementary_phase_out;
	logic                block_irq;
	logic [15:0]         count_status;
	logic                clk_run = 1'b0;
	logic                pwm_run = 1'b0;
	int                  fails = 0;
	int                  checks_done = 0;
	int                  n;
	logic [7:0]          lo;
	logic [7:0]          hi;
	logic [15:0]         v;

	always #2.5 sys_clk = ~sys_clk;

	timer_counter_deadband_block uut (.sys_clk, .srst, .cpu_req, .cpu_rdata, .block_enable,
		.mode_cfg, .data_in_external, .source_clk, .data_in, .deadband_in, .primary_out,
		.aux_out, .primary_phase_out, .complementary_phase_out, .block_irq, .count_status);
	tcdb_neighbour nb (.sys_clk, .clk_run, .pwm_run, .source_clk, .deadband_in);

	task automatic stop_test;
		if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// one strobe per access, result settled at the following falling edge
	task automatic access(input logic w, input tcdb_pkg::reg_sel_t s, input logic i,
		input logic [7:0] d);
		@(posedge sys_clk);
		cpu_req <= '{wr: w, rd: !w, sel: s, byte_idx: i, wdata: d};
		@(posedge sys_clk);
		cpu_req <= '0;
		@(negedge sys_clk);
	endtask

	task automatic wr_pair(input tcdb_pkg::reg_sel_t s, input logic [15:0] d);
		access(1'b1, s, 1'b0, d[7:0]);
		access(1'b1, s, 1'b1, d[15:8]);
	endtask

	task automatic rd_cmp;
		access(1'b0, tcdb_pkg::REG_COMPARE, 1'b0, 8'h00);
		lo = cpu_rdata;
		access(1'b0, tcdb_pkg::REG_COMPARE, 1'b1, 8'h00);
		hi = cpu_rdata;
	endtask

	task automatic wait_count(input logic [15:0] x);
		n = 0;
		while (count_status !== x && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		check(count_status, x);
	endtask

	task automatic wait_bit(ref logic s, input logic e);
		n = 0;
		while (s !== e && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic seen(ref logic s, input int k, input logic e);
		logic f = 1'b0;
		repeat (k) begin
			@(negedge sys_clk);
			f |= s;
		end
		check(f, e);
	endtask

	task automatic t_disabled;
		@(posedge sys_clk);
		mode_cfg <= '{func: tcdb_pkg::FN_COUNTER, int_on_compare: 1'b0, cmp_le: 1'b0};
		wr_pair(tcdb_pkg::REG_PERIOD, 16'h0005);
		wr_pair(tcdb_pkg::REG_COMPARE, 16'h0003);
		check(count_status, 16'h0005);
		check({primary_out, aux_out, block_irq}, 3'h0);
	endtask

	task automatic t_counter;
		@(posedge sys_clk);
		block_enable <= 1'b1;
		data_in <= 1'b1;
		clk_run <= 1'b1;
		wait_count(16'h0000);
		wait_count(16'h0005);
		seen(aux_out, 120, 1'b1);
		seen(block_irq, 120, 1'b1);
		for (int le = 0; le < 2; le++) begin
			@(posedge sys_clk);
			mode_cfg.cmp_le <= le[0];
			wait_count(16'h0003);
			cyc(15);
			check(primary_out, le[0]);
		end
		// a zero compare never comes true under less-than, so the compare source stays silent
		wr_pair(tcdb_pkg::REG_COMPARE, 16'h0000);
		@(posedge sys_clk);
		mode_cfg <= '{func: tcdb_pkg::FN_COUNTER, int_on_compare: 1'b1, cmp_le: 1'b0};
		cyc(10);
		seen(block_irq, 200, 1'b0);
		wr_pair(tcdb_pkg::REG_COMPARE, 16'h0003);
		seen(block_irq, 200, 1'b1);
		wait_count(16'h0003);
		@(posedge sys_clk);
		data_in <= 1'b0;
		cyc(30);
		v = count_status;
		cyc(64);
		check(count_status, v);
		@(posedge sys_clk);
		data_in <= 1'b1;
		wait_count(16'h0000);
		@(posedge sys_clk);
		data_in <= 1'b0;
		cyc(40);
		check(count_status, 16'h0005);
		cyc(64);
		check(count_status, 16'h0005);
	endtask

	task automatic t_read;
		@(posedge sys_clk);
		block_enable <= 1'b0;
		cyc(4);
		check(count_status, 16'h0005);
		access(1'b0, tcdb_pkg::REG_COUNT, 1'b0, 8'h00);
		check(cpu_rdata, 8'h00);
		rd_cmp();
		check(lo, 8'h05);
	endtask

	task automatic t_timer;
		@(posedge sys_clk);
		mode_cfg.func <= tcdb_pkg::FN_TIMER;
		wr_pair(tcdb_pkg::REG_PERIOD, 16'h0106);
		wr_pair(tcdb_pkg::REG_COMPARE, 16'hFFFF);
		@(posedge sys_clk);
		block_enable <= 1'b1;
		cyc(200);
		@(posedge sys_clk);
		clk_run <= 1'b0;
		cyc(20);
		v = count_status;
		access(1'b0, tcdb_pkg::REG_COUNT, 1'b0, 8'h00);
		rd_cmp();
		check({hi, lo}, v);
		check(v > 16'h00F0 && v < 16'h0100, 1'b1);
		wr_pair(tcdb_pkg::REG_COMPARE, 16'hFFFF);
		@(posedge sys_clk);
		data_in_external <= 1'b1;
		data_in <= 1'b1;
		cyc(10);
		rd_cmp();
		check({hi, lo}, v);
		@(posedge sys_clk);
		data_in <= 1'b0;
		data_in_external <= 1'b0;
		block_enable <= 1'b0;
	endtask

	task automatic t_deadband;
		@(posedge sys_clk);
		mode_cfg.func <= tcdb_pkg::FN_DEADBAND;
		wr_pair(tcdb_pkg::REG_PERIOD, 16'h0103);
		check(count_status[7:0], 8'h03);
		@(posedge sys_clk);
		block_enable <= 1'b1;
		clk_run <= 1'b1;
		pwm_run <= 1'b1;
		wait_bit(deadband_in, 1'b1);
		wait_bit(primary_phase_out, 1'b1);
		check(n >= 46 && n <= 72, 1'b1);
		cyc(2);
		check(primary_out, 1'b1);
		wait_bit(deadband_in, 1'b0);
		wait_bit(complementary_phase_out, 1'b1);
		check(n >= 46 && n <= 72, 1'b1);
		seen(block_irq, 340, 1'b1);
		@(posedge sys_clk);
		data_in <= 1'b1;
		cyc(4);
		seen(primary_phase_out, 340, 1'b0);
		@(posedge sys_clk);
		block_enable <= 1'b0;
		data_in <= 1'b0;
		cyc(3);
		check({primary_out, aux_out, complementary_phase_out, block_irq}, 4'h0);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_disabled();
		t_counter();
		t_read();
		t_timer();
		t_deadband();
		stop_test();
	end

	// the whole run needs roughly 2500 cycles; this allows more than ten times that
	initial begin
		#200000;
		fails++;
		stop_test();
	end
endmodule // timer_counter_deadband_block_test
`default_nettype wire
